/* src/cbic_cfg.svh */
`ifndef CBIC_CFG_SVH
`define CBIC_CFG_SVH

`define CBIC_XLEN 32
`define CBIC_TVEC_ALIGN_LSB 7
`define CBIC_WORD_ALIGN_LSB 2
`define CBIC_RST_PC 32'h0000_0000
`define CBIC_RST_CYCLE 64'h0000_0000_0000_0000
`define CBIC_PATCH_W 4
`define CBIC_PATCH_LSB 0
`define CBIC_IMPID_BASE 32'h0000_0000
`define CBIC_CSR_THREAD_ID 12'hf14
`define CBIC_CSR_IMPID 12'hf13
`define CBIC_CSR_TVEC 12'h305
`define CBIC_CSR_CYCLE 12'hb00
`define CBIC_CSR_CYCLEH 12'hb80

`endif

/* src/cbic_pkg.sv */
`default_nettype none
package cbic_pkg;
   typedef enum logic [3:0] {
      CBIC_ST_WAIT  = 4'b0001,
      CBIC_ST_BOOT  = 4'b0010,
      CBIC_ST_RUN   = 4'b0100,
      CBIC_ST_DEBUG = 4'b1000
   } cbic_state_t;
endpackage : cbic_pkg
`default_nettype wire

/* src/cbic_clock_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module cbic_clock_gate (
   input wire logic ref_clk,
   input wire logic enable,
   input wire logic scan_gate_force_in,
   output logic gated_clk
);
   logic latch_en;
   // latch is transparent while clock is low so the enable cannot glitch the gated clock
   always_latch begin
      if (!ref_clk) begin
         latch_en <= enable | scan_gate_force_in;
      end
   end
   assign gated_clk = ref_clk & latch_en;
endmodule : cbic_clock_gate
`default_nettype wire

/* src/cbic_core_ctrl.sv */
// Functional notes
// - A high scan gate force opens every clock gate so gated clocks run during scan.
// - The first fetch after reset uses the boot address input, with its two low bits cleared, as its program counter.
// - Without the local interrupt controller, the trap-vector base address part loads from its input on the first clock after reset.
// - Entering debug mode jumps to the debug entry address, which the integrator keeps word aligned.
// - An exception in debug mode jumps to the debug exception address, kept word aligned by the integrator.
// - A read of the thread id CSR returns the hart id input.
// - The implementation id CSR read includes the patch input, which the integrator keeps static.
// - No fetch is issued after reset while fetch enable stays low.
// - Once fetching is enabled, fetch enable is ignored until the next reset.
// - The cycle counter output always shows the current machine cycle count.
`include "cbic_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module cbic_core_ctrl #(
   parameter bit CLIC = 1'b0,
   parameter int XLEN = `CBIC_XLEN
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic scan_gate_force_in,
   input wire logic [XLEN-1:0] boot_addr,
   input wire logic [XLEN-1:0] tvec_addr,
   input wire logic [XLEN-1:0] dbg_entry_addr,
   input wire logic [XLEN-1:0] dbg_exc_addr,
   input wire logic [XLEN-1:0] hart_id,
   input wire logic [`CBIC_PATCH_W-1:0] impid_patch,
   input wire logic fetch_enable,
   input wire logic debug_req,
   input wire logic debug_exc,
   input wire logic debug_ret,
   input wire logic [XLEN-1:0] ret_pc,
   input wire logic fetch_next,
   input wire logic csr_rd,
   input wire logic [11:0] csr_addr,
   output logic fetch_req,
   output logic [XLEN-1:0] fetch_pc,
   output logic [XLEN-1:0] tvec_base,
   output logic debug_mode,
   output logic [XLEN-1:0] csr_rdata,
   output logic csr_rvalid,
   output logic [63:0] cycle_count,
   output logic gated_clk
);
   import cbic_pkg::*;

   // =====================================================
   // state
   typedef struct packed {
      cbic_state_t state;
      logic fetch_req;
      logic [XLEN-1:0] pc;
      logic [XLEN-1:0] tvec;
      logic dbg;
      logic [XLEN-1:0] rdata;
      logic rvalid;
      logic [63:0] cycle;
      logic tvec_loaded;
   } cbic_regs_t;

   cbic_regs_t r;
   cbic_regs_t next_r;

   function automatic logic [XLEN-1:0] cbic_word(input logic [XLEN-1:0] a);
      cbic_word = {a[XLEN-1:`CBIC_WORD_ALIGN_LSB], {`CBIC_WORD_ALIGN_LSB{1'b0}}};
   endfunction : cbic_word

   // =====================================================
   // next state
   always_comb begin
      next_r = r;
      next_r.cycle = r.cycle + 64'h1;
      next_r.rvalid = 1'b0;
      // trap base taken once out of reset; addresses are static so one sample suffices
      if (!r.tvec_loaded) begin
         next_r.tvec_loaded = 1'b1;
         if (!CLIC) begin
            next_r.tvec = {tvec_addr[XLEN-1:`CBIC_TVEC_ALIGN_LSB], {`CBIC_TVEC_ALIGN_LSB{1'b0}}};
         end
      end
      unique case (r.state)
         CBIC_ST_WAIT: begin
            next_r.fetch_req = 1'b0;
            if (fetch_enable) begin
               next_r.state = CBIC_ST_BOOT;
               next_r.fetch_req = 1'b1;
               next_r.pc = cbic_word(boot_addr);
            end
         end
         CBIC_ST_BOOT, CBIC_ST_RUN: begin
            // fetch_enable not looked at from here on
            next_r.fetch_req = 1'b1;
            if (fetch_next) begin
               next_r.state = CBIC_ST_RUN;
               next_r.pc = r.pc + XLEN'(32'h4);
            end
            if (debug_req) begin
               next_r.state = CBIC_ST_DEBUG;
               next_r.dbg = 1'b1;
               next_r.pc = cbic_word(dbg_entry_addr);
            end
         end
         CBIC_ST_DEBUG: begin
            next_r.fetch_req = 1'b1;
            if (debug_exc) begin
               next_r.pc = cbic_word(dbg_exc_addr);
            end else if (debug_ret) begin
               next_r.state = CBIC_ST_RUN;
               next_r.dbg = 1'b0;
               next_r.pc = cbic_word(ret_pc);
            end else if (fetch_next) begin
               next_r.pc = r.pc + XLEN'(32'h4);
            end
         end
         default: begin
            next_r.state = CBIC_ST_WAIT;
            next_r.fetch_req = 1'b0;
         end
      endcase
      if (csr_rd) begin
         next_r.rvalid = 1'b1;
         unique case (csr_addr)
            `CBIC_CSR_THREAD_ID: next_r.rdata = hart_id;
            `CBIC_CSR_IMPID: next_r.rdata = `CBIC_IMPID_BASE | XLEN'(impid_patch);
            `CBIC_CSR_TVEC: next_r.rdata = r.tvec;
            `CBIC_CSR_CYCLE: next_r.rdata = r.cycle[31:0];
            `CBIC_CSR_CYCLEH: next_r.rdata = r.cycle[63:32];
            default: next_r.rdata = '0;
         endcase
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         r.state <= CBIC_ST_WAIT;
         r.fetch_req <= 1'b0;
         r.pc <= `CBIC_RST_PC;
         r.tvec <= `CBIC_RST_PC;
         r.dbg <= 1'b0;
         r.rdata <= '0;
         r.rvalid <= 1'b0;
         r.cycle <= `CBIC_RST_CYCLE;
         r.tvec_loaded <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // =====================================================
   // clock gate: runs only while fetching, unless scan forces it
   logic gclk;
   cbic_clock_gate u_gate (
      .ref_clk(ref_clk),
      .enable(r.fetch_req),
      .scan_gate_force_in(scan_gate_force_in),
      .gated_clk(gclk)
   );
   assign gated_clk = gclk;

   assign fetch_req = r.fetch_req;
   assign fetch_pc = r.pc;
   assign tvec_base = r.tvec;
   assign debug_mode = r.dbg;
   assign csr_rdata = r.rdata;
   assign csr_rvalid = r.rvalid;
   assign cycle_count = r.cycle;
endmodule : cbic_core_ctrl
`default_nettype wire

/* dv/cbic_soc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cbic_soc_model (
   output logic [31:0] boot_addr,
   output logic [31:0] tvec_addr,
   output logic [31:0] dbg_entry_addr,
   output logic [31:0] dbg_exc_addr,
   output logic [31:0] hart_id,
   output logic [3:0] impid_patch
);
   // ==========
   // straps never move, so they stay put once fetch starts
   assign boot_addr = 32'h0000_1004;
   assign tvec_addr = 32'h0000_0180;
   assign dbg_entry_addr = 32'h0000_2008;
   assign dbg_exc_addr = 32'h0000_300c;
   assign hart_id = 32'h0000_0003;
   assign impid_patch = 4'h5;
endmodule : cbic_soc_model
`default_nettype wire

/* dv/cbic_core_ctrl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module cbic_core_ctrl_monitor (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic fetch_enable,
   input wire logic debug_req,
   input wire logic csr_rd,
   input wire logic fetch_req,
   input wire logic debug_mode,
   input wire logic csr_rvalid,
   input wire logic [31:0] boot_addr,
   input wire logic [31:0] tvec_addr,
   input wire logic [31:0] dbg_entry_addr,
   input wire logic [31:0] fetch_pc,
   input wire logic [31:0] tvec_base,
   input wire logic [63:0] cycle_count
);
   // ==========
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_start_wait: assert property (!fetch_req && !fetch_enable |=> !fetch_req)
      else $error("fetch without enable");
   a_start_pc: assert property (!fetch_req && fetch_enable |=> fetch_req && fetch_pc == boot_addr)
      else $error("bad start");
   a_fetch_latch: assert property (fetch_req |=> fetch_req)
      else $error("fetch dropped");
   a_tvec_load: assert property (fetch_req |-> tvec_base == {tvec_addr[31:7], 7'h00})
      else $error("bad tvec");
   a_debug_jump: assert property (fetch_req && !debug_mode && debug_req |=>
      debug_mode && fetch_pc == dbg_entry_addr)
      else $error("bad debug entry");
   a_csr_answer: assert property (csr_rd |=> csr_rvalid)
      else $error("no csr answer");
   a_cycle_step: assert property (1'b1 |=> cycle_count == $past(cycle_count) + 64'h1)
      else $error("cycle skipped");
   a_reset_clear: assert property (disable iff (1'b0)
      !reset_n |-> !fetch_req && !debug_mode && cycle_count == 64'h0)
      else $error("not cleared");
   cover property ($rose(fetch_req));
   cover property (debug_mode);
   cover property (csr_rvalid);
endmodule : cbic_core_ctrl_monitor
bind cbic_core_ctrl cbic_core_ctrl_monitor mon_u (.ref_clk, .reset_n, .fetch_enable, .debug_req, .csr_rd,
   .fetch_req, .debug_mode, .csr_rvalid, .boot_addr, .tvec_addr, .dbg_entry_addr, .fetch_pc, .tvec_base,
   .cycle_count);
`default_nettype wire

/* dv/cbic_core_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module cbic_core_ctrl_bench;
   // clock starts high so that reset can be lowered on the first falling edge, before any rising one
   logic ref_clk = 1, reset_n = 1, scan_gate_force_in = 0, fetch_enable = 0;
   logic debug_req = 0, debug_exc = 0, debug_ret = 0, fetch_next = 0, csr_rd = 0;
   logic fetch_req, debug_mode, csr_rvalid, gated_clk;
   logic [31:0] ret_pc = 32'h0000_4010;
   logic [11:0] csr_addr = 12'h000;
   logic [3:0] impid_patch;
   logic [31:0] boot_addr, tvec_addr, dbg_entry_addr, dbg_exc_addr, hart_id, fetch_pc, tvec_base, csr_rdata;
   logic [63:0] cycle_count, c0;
   logic [43:0] rows [4];
   int mismatches = 0, check_count = 0;
   always #12.5 ref_clk = ~ref_clk;
   cbic_soc_model soc_u (.boot_addr, .tvec_addr, .dbg_entry_addr, .dbg_exc_addr, .hart_id, .impid_patch);
   cbic_core_ctrl dut_u (.ref_clk, .reset_n, .scan_gate_force_in, .boot_addr, .tvec_addr,
      .dbg_entry_addr, .dbg_exc_addr, .hart_id, .impid_patch, .fetch_enable, .debug_req,
      .debug_exc, .debug_ret, .ret_pc, .fetch_next, .csr_rd, .csr_addr,
      .fetch_req, .fetch_pc, .tvec_base, .debug_mode, .csr_rdata, .csr_rvalid, .cycle_count, .gated_clk);
   // ==========
   task automatic chk(string n, logic [63:0] s, logic [63:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   // ~31 cycles of work, generous margin
   initial begin
      #5000;
      mismatches++;
      test_done();
   end
   initial begin
      @(negedge ref_clk) reset_n = 0;
      repeat (2) @(negedge ref_clk);
      chk("rst", cycle_count, 64'h0);
      chk("rst_ctl", {fetch_req, debug_mode}, 2'b00);
      scan_gate_force_in = 1;
      @(posedge ref_clk) #1 chk("gate", gated_clk, 1);
      @(negedge ref_clk) scan_gate_force_in = 0;
      reset_n = 1;
      @(posedge ref_clk) #1 chk("gate_shut", gated_clk, 0);
      repeat (5) @(negedge ref_clk);
      chk("wait", fetch_req, 0);
      c0 = cycle_count;
      repeat (4) @(negedge ref_clk);
      chk("cyc", cycle_count - c0, 4);
      $display("end reset");
      rows = '{{12'hf14, hart_id}, {12'hf13, 28'h0, impid_patch}, {12'h305, tvec_addr & 32'hffff_ff80}, 44'h7c0_0000_0000};
      foreach (rows[i]) begin
         csr_addr = rows[i][43:32];
         csr_rd = 1;
         @(negedge ref_clk);
         chk("csr", {csr_rvalid, csr_rdata}, {1'b1, rows[i][31:0]});
      end
      // counter words are taken at the edge that sees the read, before it counts on
      csr_addr = 12'hb00;
      c0 = cycle_count;
      @(negedge ref_clk) csr_addr = 12'hb80;
      chk("cyc_lo", csr_rdata, c0[31:0]);
      @(negedge ref_clk) csr_rd = 0;
      chk("cyc_hi", csr_rdata, (c0 + 64'h1) >> 32);
      $display("end csr");
      fetch_enable = 1;
      @(negedge ref_clk) fetch_enable = 0;
      chk("start", {fetch_req, fetch_pc}, {1'b1, boot_addr});
      chk("rv_drop", csr_rvalid, 0);
      repeat (3) @(negedge ref_clk);
      chk("held", fetch_req, 1);
      fetch_enable = 1;
      fetch_next = 1;
      @(negedge ref_clk) fetch_enable = 0;
      fetch_next = 0;
      chk("step", fetch_pc, boot_addr + 32'h4);
      debug_req = 1;
      @(negedge ref_clk) debug_req = 0;
      chk("dbg", {debug_mode, fetch_pc}, {1'b1, dbg_entry_addr});
      debug_exc = 1;
      @(negedge ref_clk) debug_exc = 0;
      chk("dexc", fetch_pc, dbg_exc_addr);
      debug_ret = 1;
      @(negedge ref_clk) debug_ret = 0;
      chk("dret", {debug_mode, fetch_pc}, {1'b0, ret_pc});
      reset_n = 0;
      #1 chk("rst2", {fetch_req, debug_mode}, 0);
      @(negedge ref_clk) reset_n = 1;
      repeat (2) @(negedge ref_clk);
      chk("wait2", fetch_req, 0);
      chk("cyc2", cycle_count, 64'h2);
      fetch_enable = 1;
      @(negedge ref_clk) fetch_enable = 0;
      chk("restart", {fetch_req, fetch_pc}, {1'b1, boot_addr});
      $display("end fetch");
      test_done();
   end
endmodule : cbic_core_ctrl_bench
`default_nettype wire
